// file: design/pss_pkg.sv
package pss_pkg;

   // Clock and timing figures
   localparam longint unsigned CLK_HZ = 50_000_000;
   localparam longint unsigned SW_TIMEOUT_S = 10;
   localparam longint unsigned DESCEND_DWELL_MS = 500;
   localparam longint unsigned SW_TIMEOUT_CYC = SW_TIMEOUT_S * CLK_HZ;
   localparam longint unsigned DESCEND_DWELL_CYC = (DESCEND_DWELL_MS * CLK_HZ) / 1000;

   // Timer width covers the 10 s count at 50 MHz
   localparam int TMR_W = 29;

   // Blower speed command, percent of full speed
   localparam int SPD_W = 7;
   localparam logic [SPD_W-1:0] SPD_ZERO = 7'h00;
   localparam logic [SPD_W-1:0] SPD_RAISE = 7'h23;
   localparam logic [SPD_W-1:0] SPD_DESCEND = 7'h1e;
   localparam logic [SPD_W-1:0] SPD_FULL = 7'h64;

   // Reset values
   localparam logic RST_VALVE = 1'b0;
   localparam logic RST_FLAG = 1'b0;

   // Sequencer states
   typedef enum logic [3:0] {
      PSS_IDLE,
      PSS_OPEN_LOWER,
      PSS_RAISE_PRE,
      PSS_SWITCH_UP,
      PSS_IRRADIATE,
      PSS_DROP,
      PSS_DESCEND,
      PSS_REVERSE,
      PSS_STOP_BLOWER,
      PSS_CLOSE_LOWER
   } pss_state_e;

endpackage : pss_pkg

// file: design/pss_tmr_if.sv
`timescale 1ns/10ps
interface pss_tmr_if;
   import pss_pkg::*;

   logic start;
   logic [TMR_W-1:0] load;
   logic expired;

   // Sequencer side
   modport ctl (
      output start,
      output load,
      input expired
   );

   // Timer side
   modport tmr (
      input start,
      input load,
      output expired
   );

endinterface : pss_tmr_if

// file: design/pss_timer.sv
`timescale 1ns/10ps
module pss_timer
   import pss_pkg::*;
(
   // Clock and synchronised reset
   input wire logic clk,
   input wire logic rst_sync_n,
   // Sequencer link
   pss_tmr_if.tmr tif
);

   logic running_q, running_d;
   logic [TMR_W-1:0] cnt_q, cnt_d;
   logic expired_q, expired_d;

   // A new start always reloads, so a stale count never leaks into the next step
   always_comb begin
      running_d = running_q;
      cnt_d = cnt_q;
      expired_d = 1'b0;
      if (tif.start) begin
         running_d = 1'b1;
         cnt_d = tif.load;
      end else if (running_q) begin
         cnt_d = cnt_q - TMR_W'(1);
         if (cnt_q <= TMR_W'(1)) begin
            running_d = 1'b0;
            expired_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         running_q <= 1'b0;
         cnt_q <= '0;
         expired_q <= 1'b0;
      end else begin
         running_q <= running_d;
         cnt_q <= cnt_d;
         expired_q <= expired_d;
      end
   end

   assign tif.expired = expired_q;

endmodule : pss_timer

// file: design/pss_sequencer.sv
// Behaviour
// - Start only when positioned and no alarm
// - First raise step opens lower valve
// - Blower forward 35% lifts to pre-irradiate
// - Lower switch swaps to upper valve
// - Full speed, hold until lower or interlock
// - Lower request swaps back to lower valve
// - Then reduce forward speed to 30%
// - Then blower full speed in reverse
// - Seat switch: speed zero, then close lower
// - At most one valve open, simultaneous swap
// - Lower switch 10 s timeout raises alarm
// - Lower timeout returns source to carousel
// - Lower-switch alarm keeps upper valve shut
// - Upper switch 10 s timeout raises alarm
// - Upper-switch alarm inhibits carousel rotation
// - Descent regulated by blower speed only
// - Each valve has its own relay output
`timescale 1ns/10ps
module pss_sequencer
   import pss_pkg::*;
#(
   parameter logic [TMR_W-1:0] SW_TIMEOUT_CYCLES = TMR_W'(SW_TIMEOUT_CYC),
   parameter logic [TMR_W-1:0] DESCEND_CYCLES = TMR_W'(DESCEND_DWELL_CYC)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Operator and carousel side
   input wire logic carousel_in_position,
   input wire logic raise_cmd,
   input wire logic lower_cmd,
   input wire logic interlock_trip,
   input wire logic alarm_clear,
   // Pressure switches
   input wire logic lower_psw,
   input wire logic upper_psw,
   // Valve relays and blower drive
   output logic lower_valve_q,
   output logic upper_valve_q,
   output logic [SPD_W-1:0] blower_speed_drive_q,
   output logic blower_reverse_q,
   // Status
   output logic busy_q,
   output logic pneu_fail_q,
   output logic fail_lower_q,
   output logic fail_upper_q,
   output logic carousel_inhibit_q
);

   // Reset release through two flops; async assert, clocked release
   logic rst_meta_q;
   logic rst_sync_n_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // Timer for switch timeouts and the descent dwell
   pss_tmr_if tif ();

   pss_timer u_timer (
      .clk(clk),
      .rst_sync_n(rst_sync_n_q),
      .tif(tif.tmr)
   );

   // State decodes used only by the output logic
   function automatic logic lower_open(input pss_state_e s);
      lower_open = (s == PSS_OPEN_LOWER) || (s == PSS_RAISE_PRE) || (s == PSS_DROP) ||
                   (s == PSS_DESCEND) || (s == PSS_REVERSE) || (s == PSS_STOP_BLOWER);
   endfunction : lower_open

   function automatic logic upper_open(input pss_state_e s);
      upper_open = (s == PSS_SWITCH_UP) || (s == PSS_IRRADIATE);
   endfunction : upper_open

   function automatic logic [SPD_W-1:0] speed_of(input pss_state_e s);
      unique case (s)
         PSS_RAISE_PRE, PSS_SWITCH_UP: speed_of = SPD_RAISE;
         PSS_IRRADIATE, PSS_DROP: speed_of = SPD_FULL;
         PSS_DESCEND: speed_of = SPD_DESCEND;
         PSS_REVERSE: speed_of = SPD_FULL;
         default: speed_of = SPD_ZERO;
      endcase
   endfunction : speed_of

   pss_state_e state_q, state_d;
   logic fail_lower_d, fail_upper_d;

   // Sequence next state; alarms set by timeouts, cleared by operator
   always_comb begin
      state_d = state_q;
      fail_lower_d = fail_lower_q;
      fail_upper_d = fail_upper_q;
      if (alarm_clear && state_q == PSS_IDLE) begin
         fail_lower_d = 1'b0; // Set below still wins in the same cycle
         fail_upper_d = 1'b0;
      end
      unique case (state_q)
         PSS_IDLE: begin
            // Latched alarm refuses new requests
            if (raise_cmd && carousel_in_position && !fail_lower_q && !fail_upper_q) begin
               state_d = PSS_OPEN_LOWER;
            end
         end
         PSS_OPEN_LOWER: begin
            if (interlock_trip) begin
               state_d = PSS_STOP_BLOWER;
            end else begin
               state_d = PSS_RAISE_PRE;
            end
         end
         PSS_RAISE_PRE: begin
            if (interlock_trip) begin
               state_d = PSS_DESCEND;
            end else if (lower_psw) begin
               state_d = PSS_SWITCH_UP;
            end else if (tif.expired) begin
               fail_lower_d = 1'b1;
               state_d = PSS_DESCEND;
            end
         end
         PSS_SWITCH_UP: begin
            state_d = interlock_trip ? PSS_DROP : PSS_IRRADIATE;
         end
         PSS_IRRADIATE: begin
            // Source stays up until the operator lowers it or the interlock trips
            if (lower_cmd || interlock_trip) begin
               state_d = PSS_DROP;
            end
         end
         PSS_DROP: state_d = PSS_DESCEND;
         PSS_DESCEND: begin
            if (tif.expired) begin
               state_d = PSS_REVERSE;
            end
         end
         PSS_REVERSE: begin
            if (upper_psw) begin
               state_d = PSS_STOP_BLOWER;
            end else if (tif.expired) begin
               fail_upper_d = 1'b1;
               state_d = PSS_STOP_BLOWER;
            end
         end
         PSS_STOP_BLOWER: state_d = PSS_CLOSE_LOWER;
         PSS_CLOSE_LOWER: state_d = PSS_IDLE;
      endcase
   end

   // Timer restarts on entry to each timed step
   always_comb begin
      tif.start = 1'b0;
      tif.load = SW_TIMEOUT_CYCLES;
      if (state_d != state_q) begin
         unique case (state_d)
            PSS_RAISE_PRE, PSS_REVERSE: tif.start = 1'b1;
            PSS_DESCEND: begin
               tif.start = 1'b1;
               tif.load = DESCEND_CYCLES;
            end
            default: tif.start = 1'b0;
         endcase
      end
   end

   // Output next values follow the next state, so the pins come straight from flops
   logic lower_valve_d, upper_valve_d, blower_reverse_d, busy_d;
   logic [SPD_W-1:0] blower_speed_drive_d;

   always_comb begin
      lower_valve_d = lower_open(state_d);
      // Lower-switch alarm vetoes the upper valve as a last guard
      upper_valve_d = upper_open(state_d) && !fail_lower_d;
      // Speed and direction are the only descent control; no brake exists
      blower_speed_drive_d = speed_of(state_d);
      blower_reverse_d = (state_d == PSS_REVERSE);
      busy_d = (state_d != PSS_IDLE);
   end

   always_ff @(posedge clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         state_q <= PSS_IDLE;
         fail_lower_q <= RST_FLAG;
         fail_upper_q <= RST_FLAG;
         pneu_fail_q <= RST_FLAG;
         carousel_inhibit_q <= RST_FLAG;
         lower_valve_q <= RST_VALVE;
         upper_valve_q <= RST_VALVE;
         blower_speed_drive_q <= SPD_ZERO;
         blower_reverse_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fail_lower_q <= fail_lower_d;
         fail_upper_q <= fail_upper_d;
         pneu_fail_q <= fail_lower_d || fail_upper_d;
         carousel_inhibit_q <= fail_upper_d;
         lower_valve_q <= lower_valve_d;
         upper_valve_q <= upper_valve_d;
         blower_speed_drive_q <= blower_speed_drive_d;
         blower_reverse_q <= blower_reverse_d;
         busy_q <= busy_d;
      end
   end

   // Checks on the sequence
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n_q);

   sequence s_swap_to_upper;
      upper_valve_q && !lower_valve_q && blower_speed_drive_q == SPD_RAISE;
   endsequence

   sequence s_full_hold;
      blower_speed_drive_q == SPD_FULL && !blower_reverse_q;
   endsequence

   sequence s_swap_to_lower;
      lower_valve_q && !upper_valve_q && blower_speed_drive_q == SPD_FULL;
   endsequence

   sequence s_slow_descent;
      lower_valve_q && blower_speed_drive_q == SPD_DESCEND && !blower_reverse_q;
   endsequence

   a_start_gate: assert property (
      (state_q == PSS_IDLE && state_d == PSS_OPEN_LOWER) |-> carousel_in_position && !pneu_fail_q)
      else $error("raise started while unpositioned or alarmed");

   a_open_then_blow: assert property (
      (state_q == PSS_IDLE && state_d == PSS_OPEN_LOWER)
      |=> lower_valve_q && !upper_valve_q && blower_speed_drive_q == SPD_ZERO
      ##1 ($past(interlock_trip) || (blower_speed_drive_q == SPD_RAISE && !blower_reverse_q)))
      else $error("lower valve not opened before 35 percent lift");

   a_switch_up: assert property (
      (state_q == PSS_RAISE_PRE && lower_psw && !interlock_trip) |=> s_swap_to_upper ##1 s_full_hold)
      else $error("valve swap or full speed missing after lower switch");

   a_hold_up: assert property (
      (state_q == PSS_IRRADIATE && !lower_cmd && !interlock_trip) |=> upper_valve_q and s_full_hold)
      else $error("irradiate position not held");

   a_lower_steps: assert property (
      (state_q == PSS_IRRADIATE && lower_cmd) |=> s_swap_to_lower ##1 s_slow_descent)
      else $error("lowering steps out of order");

   a_reverse_full: assert property (
      (state_q == PSS_DESCEND && tif.expired) |=> blower_reverse_q && blower_speed_drive_q == SPD_FULL)
      else $error("reverse full speed missing after descent");

   a_seat_stop: assert property (
      (state_q == PSS_REVERSE && upper_psw)
      |=> (blower_speed_drive_q == SPD_ZERO && lower_valve_q) ##1 !lower_valve_q ##1 !busy_q)
      else $error("seat stop sequence wrong");

   a_one_valve: assert property (
      busy_q && $past(busy_q) && state_q != PSS_IDLE && state_q != PSS_CLOSE_LOWER
      |-> lower_valve_q != upper_valve_q)
      else $error("valves not exclusive during transport");

   a_lower_timeout: assert property (
      (state_q == PSS_RAISE_PRE && !lower_psw && !interlock_trip && tif.expired)
      |=> (pneu_fail_q && fail_lower_q) and s_slow_descent)
      else $error("lower switch timeout not handled");

   a_no_upper_fail: assert property (
      fail_lower_q |-> !upper_valve_q)
      else $error("upper valve open under lower alarm");

   a_upper_timeout: assert property (
      (state_q == PSS_REVERSE && !upper_psw && tif.expired)
      |=> pneu_fail_q && carousel_inhibit_q && blower_speed_drive_q == SPD_ZERO)
      else $error("upper switch timeout not handled");

   a_alarm_latch: assert property (
      (pneu_fail_q && !alarm_clear) |=> pneu_fail_q ##1 (pneu_fail_q || $past(alarm_clear)))
      else $error("alarm dropped without clear");

endmodule : pss_sequencer

// file: verif/pss_plant_model.sv
`timescale 1ns/10ps
// Air column model: carrier position follows the valves and blower command
module pss_plant_model
   import pss_pkg::*;
(
   // Clock
   input wire logic clk,
   // Valve relays and blower drive
   input wire logic lower_valve,
   input wire logic upper_valve,
   input wire logic [SPD_W-1:0] speed,
   input wire logic reverse,
   // Bench controls: travel times and stalled carrier
   input wire logic [3:0] lift_dly,
   input wire logic [3:0] seat_dly,
   input wire logic stall_lift,
   input wire logic stall_seat,
   // Pressure switches
   output logic lower_psw,
   output logic upper_psw
);
   logic [1:0] pos = 2'h0;
   logic [3:0] cnt = 4'h0;
   logic seated = 1'b0;
   wire run = speed != SPD_ZERO;

   // One zone per move; a stalled carrier never reaches its switch
   always @(posedge clk) begin
      cnt <= 4'h0;
      if (!run || !reverse)
         seated <= 1'b0;
      if (pos == 2'h0 && lower_valve && run && !reverse && !stall_lift) begin
         cnt <= cnt + 4'h1;
         if (cnt >= lift_dly)
            pos <= 2'h1;
      end else if (pos == 2'h1 && upper_valve && run)
         pos <= 2'h2;
      else if (pos == 2'h2 && lower_valve)
         pos <= 2'h1;
      else if (pos != 2'h2 && run && reverse && !stall_seat && !seated) begin
         cnt <= cnt + 4'h1;
         if (cnt >= seat_dly) begin
            pos <= 2'h0;
            seated <= 1'b1;
         end
      end
   end

   // Switch levels seen by the sequencer
   assign lower_psw = pos == 2'h1 && lower_valve && !reverse;
   assign upper_psw = seated;
endmodule : pss_plant_model

// file: verif/tb.sv
`timescale 1ns/10ps
// Driver queues each expected output step, monitor checks every change
module tb;
   import pss_pkg::*;

   localparam logic [TMR_W-1:0] SWT = 29'h32;
   localparam logic [TMR_W-1:0] DWC = 29'ha;
   // Gap windows in cycles, derived from SWT and DWC
   localparam int TO_LO = 50;
   localparam int TO_HI = 53;
   localparam int DW_LO = 10;
   localparam int DW_HI = 12;
   localparam int LIMIT = 4000;
   localparam logic [3:0] F_LO = 4'hc;
   localparam logic [3:0] F_UP = 4'hb;

   typedef struct packed {
      logic lv;
      logic uv;
      logic [SPD_W-1:0] spd;
      logic rev;
      logic busy;
      logic [3:0] flg;
   } pss_obs_s;
   typedef struct {
      pss_obs_s obs;
      int lo;
      int hi;
   } pss_exp_s;

   logic clk, rst_n, carousel_in_position, raise_cmd, lower_cmd, interlock_trip, alarm_clear;
   logic lower_psw, upper_psw, lower_valve_q, upper_valve_q, blower_reverse_q, busy_q;
   logic pneu_fail_q, fail_lower_q, fail_upper_q, carousel_inhibit_q, stall_lift, stall_seat;
   logic [SPD_W-1:0] blower_speed_drive_q;
   logic [3:0] lift_dly, seat_dly;
   pss_exp_s expq[$];
   pss_exp_s e;
   pss_obs_s cur, prev;
   int cyc, tlast, n_mismatch, n_compared;

   pss_sequencer #(.SW_TIMEOUT_CYCLES(SWT), .DESCEND_CYCLES(DWC)) u_pss_sequencer (
      .clk, .rst_n, .carousel_in_position, .raise_cmd, .lower_cmd, .interlock_trip, .alarm_clear,
      .lower_psw, .upper_psw, .lower_valve_q, .upper_valve_q, .blower_speed_drive_q, .blower_reverse_q,
      .busy_q, .pneu_fail_q, .fail_lower_q, .fail_upper_q, .carousel_inhibit_q);

   pss_plant_model u_pss_plant_model (.clk(clk), .lower_valve(lower_valve_q), .upper_valve(upper_valve_q),
      .speed(blower_speed_drive_q), .reverse(blower_reverse_q), .lift_dly(lift_dly), .seat_dly(seat_dly),
      .stall_lift(stall_lift), .stall_seat(stall_seat), .lower_psw(lower_psw), .upper_psw(upper_psw));

   assign cur = {lower_valve_q, upper_valve_q, blower_speed_drive_q, blower_reverse_q, busy_q,
                 pneu_fail_q, fail_lower_q, fail_upper_q, carousel_inhibit_q};

   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic stop_test();
      $display("counts: compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   // Monitor: any unqueued change, or a step outside its gap window, is wrong
   always @(negedge clk) begin
      cyc++;
      if (rst_n && cur !== prev) begin
         n_compared++;
         if (expq.size() == 0) begin
            n_mismatch++;
            $display("wrong value outputs expected no change seen %h", cur);
         end else begin
            e = expq.pop_front();
            if (cur !== e.obs || cyc - tlast < e.lo || cyc - tlast > e.hi) begin
               n_mismatch++;
               $display("wrong value outputs expected %h gap %0d..%0d seen %h gap %0d",
                        e.obs, e.lo, e.hi, cur, cyc - tlast);
            end
         end
         tlast = cyc;
      end
      prev = cur;
      if (cyc > LIMIT) begin
         n_mismatch++;
         $display("wrong value cycle count expected below %0d seen %0d", LIMIT, cyc);
         stop_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic ex(input logic lv, input logic uv, input logic [SPD_W-1:0] spd, input logic rev,
                     input logic bz, input logic [3:0] flg, input int lo, input int hi);
      expq.push_back('{obs: {lv, uv, spd, rev, bz, flg}, lo: lo, hi: hi});
   endtask : ex

   task automatic wait_done(input string name);
      for (int k = 0; k < 600 && expq.size() != 0; k++)
         @(negedge clk);
      tick(4);
      if (expq.size() != 0) begin
         n_mismatch++;
         $display("wrong value pending steps expected 0 seen %0d", expq.size());
      end
      $display("test %s done", name);
   endtask : wait_done

   task automatic go();
      lift_dly = 4'($urandom_range(1, 12));
      seat_dly = 4'($urandom_range(1, 12));
      raise_cmd = 1'b1;
      tick(1);
      raise_cmd = 1'b0;
   endtask : go

   // Raise to the irradiate position, then hold there a random time
   task automatic up();
      ex(1, 0, SPD_ZERO, 0, 1, 4'h0, 1, 99999);
      ex(1, 0, SPD_RAISE, 0, 1, 4'h0, 1, 1);
      ex(0, 1, SPD_RAISE, 0, 1, 4'h0, 1, 25);
      ex(0, 1, SPD_FULL, 0, 1, 4'h0, 1, 1);
      go();
      wait_done("raise");
      tick($urandom_range(5, 30));
   endtask : up

   // Lower by command or interlock; a stalled carrier ends in the seat alarm
   task automatic down(input logic lock, input logic stall);
      logic [3:0] f;
      f = stall ? F_UP : 4'h0;
      ex(1, 0, SPD_FULL, 0, 1, 4'h0, 1, 99999);
      ex(1, 0, SPD_DESCEND, 0, 1, 4'h0, 1, 1);
      ex(1, 0, SPD_FULL, 1, 1, 4'h0, DW_LO, DW_HI);
      ex(1, 0, SPD_ZERO, 0, 1, f, stall ? TO_LO : 1, stall ? TO_HI : 25);
      ex(0, 0, SPD_ZERO, 0, 1, f, 1, 1);
      ex(0, 0, SPD_ZERO, 0, 0, f, 1, 1);
      stall_seat = stall;
      interlock_trip = lock;
      lower_cmd = !lock;
      tick(1);
      interlock_trip = 1'b0;
      lower_cmd = 1'b0;
      wait_done("lower");
      stall_seat = 1'b0;
   endtask : down

   // A latched alarm refuses raise until cleared
   task automatic clear();
      go();
      tick(10);
      ex(0, 0, SPD_ZERO, 0, 0, 4'h0, 1, 99999);
      alarm_clear = 1'b1;
      tick(1);
      alarm_clear = 1'b0;
      wait_done("clear");
   endtask : clear

   // Main sequence
   initial begin
      void'($urandom(46));
      {rst_n, raise_cmd, lower_cmd, interlock_trip, alarm_clear, stall_lift, stall_seat} = '0;
      carousel_in_position = 1'b1;
      lift_dly = 4'h3;
      seat_dly = 4'h3;
      prev = '0;
      tick(10);
      rst_n = 1'b1;
      tick(5);
      carousel_in_position = 1'b0;
      go();
      tick(10);
      carousel_in_position = 1'b1;
      wait_done("no carousel");
      up();
      down(1'b0, 1'b0);
      up();
      down(1'b1, 1'b0);
      // Interlock in the 35 percent lift aborts to lowering without an alarm
      stall_lift = 1'b1;
      ex(1, 0, SPD_ZERO, 0, 1, 4'h0, 1, 99999);
      ex(1, 0, SPD_RAISE, 0, 1, 4'h0, 1, 1);
      ex(1, 0, SPD_DESCEND, 0, 1, 4'h0, 5, 5);
      ex(1, 0, SPD_FULL, 1, 1, 4'h0, DW_LO, DW_HI);
      ex(1, 0, SPD_ZERO, 0, 1, 4'h0, 1, 25);
      ex(0, 0, SPD_ZERO, 0, 1, 4'h0, 1, 1);
      ex(0, 0, SPD_ZERO, 0, 0, 4'h0, 1, 1);
      go();
      tick(5);
      interlock_trip = 1'b1;
      tick(1);
      interlock_trip = 1'b0;
      wait_done("raise interlock");
      ex(1, 0, SPD_ZERO, 0, 1, 4'h0, 1, 99999);
      ex(1, 0, SPD_RAISE, 0, 1, 4'h0, 1, 1);
      ex(1, 0, SPD_DESCEND, 0, 1, F_LO, TO_LO, TO_HI);
      ex(1, 0, SPD_FULL, 1, 1, F_LO, DW_LO, DW_HI);
      ex(1, 0, SPD_ZERO, 0, 1, F_LO, 1, 25);
      ex(0, 0, SPD_ZERO, 0, 1, F_LO, 1, 1);
      ex(0, 0, SPD_ZERO, 0, 0, F_LO, 1, 1);
      go();
      wait_done("lift stall");
      stall_lift = 1'b0;
      clear();
      up();
      down(1'b0, 1'b1);
      clear();
      up();
      down(1'b0, 1'b0);
      stop_test();
   end
endmodule : tb
